// ---- src/clock_switch_status_control.v ----
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "clock_switch_map.vh"
module clock_switch_status_control (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // startup configuration, sampled after reset release
  input  wire [2:0]  startup_source,
  input  wire [3:0]  startup_divider,
  // oscillator ready indications, one per source code, from analog
  input  wire [7:0]  source_ready,
  // clock mux controls
  output reg  [2:0]  active_source,
  output reg  [3:0]  active_divider,
  output reg         secondary_high_power,
  // interrupt
  output wire        irq
);
  reg  [2:0]  cur_src_r;
  reg  [3:0]  cur_div_r;
  reg  [2:0]  req_src_r;
  reg  [3:0]  req_div_r;
  reg         hold_r;
  reg         spwr_r;
  reg         nrdy_r;
  reg         boot_r;
  reg  [`IRQ_WIDTH-1:0] irq_stat_r;
  reg  [`IRQ_WIDTH-1:0] irq_mask_r;
  reg  [2:0]  rdy_s1_r;
  reg  [2:0]  rdy_s2_r;
  reg  [2:0]  rdy_s3_r;
  reg  [7:0]  rdy_m1_r;
  reg  [7:0]  rdy_m2_r;
  reg  [7:0]  rdy_m3_r;
  reg  [7:0]  rdy_clean_r;
  reg         rdy_seen_r;
  wire        tick;
  wire        wr_en;
  wire        rd_en;
  wire        switching;
  wire        new_ready;
  wire        oscillator_ready_flag;
  wire        do_switch;
  wire        hold_event;
  wire        wr_request;
  wire        wr_control;
  wire        wr_irq_stat;
  wire        wr_irq_mask;
  wire        addr_ok;
  wire        ready_for_req;
  reg  [7:0]  read_mux;
  reg  [`IRQ_WIDTH-1:0] irq_set;
  integer     i;

  instr_tick u_tick (
    .clock  (clock),
    .resetn (resetn),
    .tick   (tick)
  );

  // one compare per register, shared by the write strobes and the error decode
  function reg_hit(input [7:0] addr, input [7:0] target);
    reg_hit = (addr == target);
  endfunction

  function addr_mapped(input [7:0] addr);
    addr_mapped = reg_hit(addr, `ADDR_CURRENT_STATUS) ||
                  reg_hit(addr, `ADDR_SWITCH_CONTROL) ||
                  reg_hit(addr, `ADDR_REQUEST) ||
                  reg_hit(addr, `ADDR_IRQ_STATUS) ||
                  reg_hit(addr, `ADDR_IRQ_MASK);
  endfunction

  // apb: zero wait states, unmapped addresses answer with an error
  assign pready      = 1'h1;
  assign wr_en       = psel && penable && pwrite;
  assign rd_en       = psel && !penable && !pwrite;
  assign addr_ok     = addr_mapped(paddr);
  assign pslverr     = psel && penable && !addr_ok;
  assign wr_request  = wr_en && reg_hit(paddr, `ADDR_REQUEST);
  assign wr_control  = wr_en && reg_hit(paddr, `ADDR_SWITCH_CONTROL);
  assign wr_irq_stat = wr_en && reg_hit(paddr, `ADDR_IRQ_STATUS);
  assign wr_irq_mask = wr_en && reg_hit(paddr, `ADDR_IRQ_MASK);

  // ready inputs are asynchronous: three stages, change accepted once stages two and three agree
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_m1_r    <= 8'h00;
      rdy_m2_r    <= 8'h00;
      rdy_m3_r    <= 8'h00;
      rdy_clean_r <= 8'h00;
    end else begin
      rdy_m1_r <= source_ready;
      rdy_m2_r <= rdy_m1_r;
      rdy_m3_r <= rdy_m2_r;
      for (i = 0; i < 8; i = i + 1) begin
        if (rdy_m2_r[i] == rdy_m3_r[i]) begin
          rdy_clean_r[i] <= rdy_m3_r[i];
        end
      end
    end
  end

  // request source delayed to match the ready synchroniser, so a fresh request
  // is never switched on a ready bit that still belongs to the old source
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_s1_r <= 3'h0;
      rdy_s2_r <= 3'h0;
      rdy_s3_r <= 3'h0;
    end else begin
      rdy_s1_r <= req_src_r;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
    end
  end

  assign ready_for_req = (rdy_s3_r == req_src_r);
  // switching also covers a divider-only change
  assign switching = (cur_src_r != req_src_r) || (cur_div_r != req_div_r);
  assign oscillator_ready_flag      = !switching;
  // a pure divider change needs no new oscillator, so it is ready at once
  assign new_ready = switching &&
                     ((cur_src_r == req_src_r) || rdy_clean_r[req_src_r]);

  // new-ready is latched on an instruction tick, so it lags readiness by at most one
  assign do_switch  = nrdy_r && !hold_r && tick && ready_for_req;
  assign hold_event = new_ready && hold_r && !rdy_seen_r;

  // configuration in force when code starts, caught at the first edge after release
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boot_r <= 1'h1;
    end else begin
      boot_r <= 1'h0;
    end
  end

  // requested source and divider; software owns them after the boot edge
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_src_r <= 3'h0;
      req_div_r <= 4'h0;
    end else if (boot_r) begin
      req_src_r <= startup_source;
      req_div_r <= startup_divider;
    end else if (wr_request) begin
      req_src_r <= pwdata[`REQ_SRC_HI:`REQ_SRC_LO];
      req_div_r <= pwdata[`REQ_DIV_HI:`REQ_DIV_LO];
    end
  end

  // current source and divider load the startup values at the boot edge, then move only on a granted switch
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_src_r <= 3'h0;
      cur_div_r <= 4'h0;
    end else if (boot_r) begin
      cur_src_r <= startup_source;
      cur_div_r <= startup_divider;
    end else if (do_switch) begin
      cur_src_r <= req_src_r;
      cur_div_r <= req_div_r;
    end
  end

  // new-ready: raised on a tick, dropped by the switch or when readiness goes
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nrdy_r <= 1'h0;
    end else if (boot_r) begin
      nrdy_r <= 1'h0;
    end else if (do_switch) begin
      nrdy_r <= 1'h0;
    end else if (!new_ready) begin
      nrdy_r <= 1'h0;
    end else if (tick) begin
      nrdy_r <= 1'h1;
    end
  end

  // remembers that a held switch was reported, so the interrupt fires once
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_seen_r <= 1'h0;
    end else if (boot_r) begin
      rdy_seen_r <= 1'h0;
    end else begin
      rdy_seen_r <= new_ready && hold_r;
    end
  end

  // control bits; status fields have no write path
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_r <= 1'h0;
      spwr_r <= 1'h0;
    end else if (wr_control) begin
      hold_r <= pwdata[`CTL_HOLD_BIT];
      spwr_r <= pwdata[`CTL_SPWR_BIT];
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_mask_r <= {`IRQ_WIDTH{1'h0}};
    end else if (wr_irq_mask) begin
      irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // sticky events, set wins over write-one-to-clear
  always @* begin
    irq_set = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_HOLD_BIT] = hold_event;
    irq_set[`IRQ_DONE_BIT] = do_switch;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= {`IRQ_WIDTH{1'b0}};
    end else if (wr_irq_stat) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[`IRQ_WIDTH-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // level output: clearing the status bit or its mask drops it at once
  assign irq = |(irq_stat_r & irq_mask_r);

  always @* begin
    read_mux = 8'h00;
    case (paddr)
      `ADDR_CURRENT_STATUS: begin
        read_mux[`CUR_SRC_HI:`CUR_SRC_LO] = cur_src_r;
        read_mux[`CUR_DIV_HI:`CUR_DIV_LO] = cur_div_r;
      end
      `ADDR_SWITCH_CONTROL: begin
        read_mux[`CTL_HOLD_BIT] = hold_r;
        read_mux[`CTL_SPWR_BIT] = spwr_r;
        read_mux[`CTL_OSCILLATOR_READY_FLAG_BIT] = oscillator_ready_flag;
        read_mux[`CTL_NRDY_BIT] = nrdy_r;
      end
      `ADDR_REQUEST: begin
        read_mux[`REQ_SRC_HI:`REQ_SRC_LO] = req_src_r;
        read_mux[`REQ_DIV_HI:`REQ_DIV_LO] = req_div_r;
      end
      `ADDR_IRQ_STATUS: begin
        read_mux[`IRQ_WIDTH-1:0] = irq_stat_r;
      end
      `ADDR_IRQ_MASK: begin
        read_mux[`IRQ_WIDTH-1:0] = irq_mask_r;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // read data captured in setup so it is stable through the access phase
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= {24'h000000, read_mux};
    end
  end

  // mux controls come straight from flops, so the clock mux never sees a glitch
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      active_source        <= 3'h0;
      active_divider       <= 4'h0;
      secondary_high_power <= 1'h0;
    end else begin
      active_source        <= cur_src_r;
      active_divider       <= cur_div_r;
      secondary_high_power <= spwr_r;
    end
  end
endmodule // clock_switch_status_control
`default_nettype wire

// ---- src/clock_switch_map.vh ----
`ifndef CLOCK_SWITCH_MAP_VH
`define CLOCK_SWITCH_MAP_VH
// register byte addresses
`define ADDR_CURRENT_STATUS  8'h00
`define ADDR_SWITCH_CONTROL  8'h04
`define ADDR_REQUEST         8'h08
`define ADDR_IRQ_STATUS      8'h0c
`define ADDR_IRQ_MASK        8'h10
// current status fields
`define CUR_SRC_HI           6
`define CUR_SRC_LO           4
`define CUR_DIV_HI           3
`define CUR_DIV_LO           0
// switch control fields
`define CTL_HOLD_BIT         7
`define CTL_SPWR_BIT         6
`define CTL_OSCILLATOR_READY_FLAG_BIT         4
`define CTL_NRDY_BIT         3
// request register fields (same layout as current status)
`define REQ_SRC_HI           6
`define REQ_SRC_LO           4
`define REQ_DIV_HI           3
`define REQ_DIV_LO           0
// interrupt status bits
`define IRQ_HOLD_BIT         0
`define IRQ_DONE_BIT         1
`define IRQ_WIDTH            2
// instruction clock is the system clock divided by four
`define ICLK_DIV             2'h3
`endif

// ---- src/instr_tick.v ----
`timescale 1ns/100ps
`default_nettype none
`include "clock_switch_map.vh"
module instr_tick (
  // clock and reset
  input  wire       clock,
  input  wire       resetn,
  // one-cycle enable at instruction rate
  output wire       tick
);
  reg [1:0] count_r;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_r <= 2'h0;
    end else begin
      count_r <= (count_r == `ICLK_DIV) ? 2'h0 : count_r + 2'h1;
    end
  end

  assign tick = (count_r == `ICLK_DIV);
endmodule // instr_tick
`default_nettype wire

// ---- verification/clock_switch_status_control_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module sw_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // mux side
  input wire logic [2:0]  active_source,
  input wire logic [3:0]  active_divider,
  input wire logic        secondary_high_power,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire rd = psel && penable && !pwrite;
  wire map = paddr <= 8'h10 && paddr[1:0] == 2'h0;
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  status_pad_a: assert property (rd && paddr == 8'h00 |-> !prdata[7])
    else $error("status pad bit set");
  ctl_pad_a: assert property (rd && paddr == 8'h04 |-> {prdata[5], prdata[2:0]} == 4'h0)
    else $error("control pad bits set");
  cur_fields_a: assert property (rd && paddr == 8'h00 |->
    prdata[6:0] == {active_source, active_divider})
    else $error("status differs from mux");
  err_map_a: assert property (psel && penable |-> pslverr == !map)
    else $error("pslverr wrong");
  unmapped_zero_a: assert property (rd && !map |-> prdata == 32'h0)
    else $error("unmapped read nonzero");
  power_sel_a: assert property (psel && penable && pwrite && paddr == 8'h04 |->
    ##2 secondary_high_power == $past(pwdata[6], 2))
    else $error("power select not applied");
  switch_gap_a: assert property ($changed(active_source) |=>
    $stable(active_source)[*3])
    else $error("switch off instruction cycle");
  cover property ($changed(active_source));
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($rose(secondary_high_power));
endmodule // sw_chk
bind clock_switch_status_control sw_chk i_chk (.clock, .resetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pslverr, .active_source, .active_divider,
  .secondary_high_power, .irq);
`default_nettype wire

// ---- verification/clock_switch_status_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module clock_switch_status_control_tb;
  logic        clock = 1'h0;
  logic        resetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pready, pslverr, irq, shp;
  logic [7:0]  paddr = 8'h00, source_ready = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  active_source, s, s2, s3;
  logic [3:0]  active_divider, d, d2;
  logic [32:0] exp_q[$];
  int          errors = 0, n_checks = 0, seed = 36490;
  always #12.5 clock = ~clock;
  clock_switch_status_control i_dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .startup_source(s), .startup_divider(d),
    .source_ready, .active_source, .active_divider, .secondary_high_power(shp), .irq);
  task stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string nm, input logic [32:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task tmo(input int k);
    if (k >= 60) begin
      errors++;
      stop_test;
    end
  endtask
  // reads note their expected {pslverr, prdata}; the monitor compares
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [32:0] e);
    int k;
    if (!w) exp_q.push_back(e);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, dt};
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 60);
    tmo(k);
    {psel, penable} <= 2'h0;
    #1;
  endtask
  // sel 0 waits for irq, sel 1 for the mux to reach source x
  task wt(input logic sel, input logic [2:0] x);
    int k;
    k = 0;
    while ((sel ? active_source !== x : irq !== 1'h1) && k < 60) begin
      @(posedge clock);
      #1;
      k++;
    end
    tmo(k);
  endtask
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    s = $random(seed);
    d = $random(seed);
    d2 = $random(seed);
    s2 = s + 3'h1;
    s3 = s + 3'h3;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    repeat (2) @(posedge clock);
    xfer(0, 8'h00, 0, {26'h0, s, d});
    xfer(0, 8'h04, 0, 33'h10);
    xfer(1, 8'h00, $random(seed), 0);
    xfer(0, 8'h00, 0, {26'h0, s, d});
    xfer(1, 8'h04, 32'hff, 0);
    xfer(0, 8'h04, 0, 33'hd0);
    check("secondary_high_power", shp, 1);
    xfer(1, 8'h10, 32'h3, 0);
    xfer(1, 8'h08, {s2, d2}, 0);
    xfer(0, 8'h04, 0, 33'hc0);
    @(posedge clock);
    source_ready <= 8'h01 << s2;
    wt(0, 0);
    check("active_source", active_source, s);
    xfer(0, 8'h04, 0, 33'hc8);
    xfer(0, 8'h0c, 0, 33'h1);
    xfer(1, 8'h0c, 32'h1, 0);
    check("irq", irq, 0);
    xfer(1, 8'h04, 32'h40, 0);
    wt(1, s2);
    check("active_divider", active_divider, d2);
    xfer(0, 8'h04, 0, 33'h50);
    check("irq", irq, 1);
    xfer(1, 8'h10, 0, 0);
    check("irq", irq, 0);
    xfer(0, 8'h0c, 0, 33'h2);
    xfer(1, 8'h0c, 32'h2, 0);
    xfer(1, 8'h10, 32'h3, 0);
    check("irq", irq, 0);
    @(posedge clock);
    source_ready <= 8'hff;
    xfer(1, 8'h08, {s3, d}, 0);
    wt(1, s3);
    check("active_divider", active_divider, d);
    xfer(0, 8'h14, 0, {1'h1, 32'h0});
    stop_test;
  end
endmodule // clock_switch_status_control_tb
`default_nettype wire
